/* File: rtl/vcrb_pkg.sv */
package vcrb_pkg;
  // register byte offsets on the AXI4-Lite window
  localparam logic [7:0]  OFS_CMD       = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_WIDTH     = 8'h08;
  localparam logic [7:0]  OFS_HEIGHT    = 8'h0c;
  localparam logic [7:0]  OFS_TOP       = 8'h10;
  localparam logic [7:0]  OFS_LEFT      = 8'h14;
  localparam logic [7:0]  OFS_POST      = 8'h18;
  localparam logic [7:0]  OFS_PREVIEW   = 8'h1c;
  localparam logic [7:0]  OFS_WRPTR     = 8'h20;
  // command register bits (write one to fire)
  localparam int          CMD_CLEAR_BIT = 0;
  localparam int          CMD_RESET_BIT = 1;
  localparam int          CMD_CAL_BIT   = 2;
  localparam int          CMD_TRIG_BIT  = 3;
  // status register fields
  localparam int          ST_WRITE_BIT  = 0;
  localparam int          ST_WRAP_BIT   = 1;
  localparam int          ST_TRIG_BIT   = 2;
  localparam int          ST_STATE_LSB  = 4;
  // preview register fields
  localparam int          PV_GAIN_LSB   = 0;
  localparam int          PV_RGB_BIT    = 4;
  // geometry
  localparam int          DIM_W         = 12;
  localparam logic [11:0] WIDTH_STEP    = 12'h00a;
  localparam logic [12:0] PREVIEW_COLS  = 13'h0280;
  localparam logic [12:0] PREVIEW_ROWS  = 13'h01e0;
  // preview gain codes
  localparam logic [1:0]  GAIN_X1       = 2'h0;
  localparam logic [1:0]  GAIN_X2       = 2'h1;
  localparam logic [1:0]  GAIN_X4       = 2'h2;
  // reset values before the boot settings are loaded
  localparam logic [11:0] RST_DIM       = 12'h000;
  localparam logic [15:0] RST_POST      = 16'h0000;
  localparam logic [1:0]  RST_GAIN      = GAIN_X1;
  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    VCRB_IDLE    = 2'b00,
    VCRB_CAPTURE = 2'b01,
    VCRB_POST    = 2'b10,
    VCRB_STOP    = 2'b11
  } vcrb_state_e;
endpackage : vcrb_pkg

/* File: rtl/vcrb_preview_slice.sv */
`timescale 1ns/1ps
module vcrb_preview_slice
  import vcrb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        inValid,
  input  wire logic [9:0]  inData,
  input  wire logic [1:0]  gain,
  input  wire logic        rgbMode,
  output logic             prevValid,
  output logic [7:0]       prevData,
  output logic             prevRgbMode
);
  import vcrb_pkg::*;

  // pick an 8-bit window; upper bits are dropped, never saturated, so bright
  // samples wrap around at higher gain
  function automatic logic [7:0] sliceBits(input logic [9:0] s, input logic [1:0] g);
    case (g)
      GAIN_X1: sliceBits = s[9:2];
      GAIN_X2: sliceBits = s[8:1];
      default: sliceBits = s[7:0];
    endcase
  endfunction : sliceBits

  // preview register stage
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prevValid   <= 1'b0;
      prevData    <= 8'h00;
      prevRgbMode <= 1'b0;
    end else begin
      prevValid   <= inValid;
      prevData    <= inValid ? sliceBits(inData, gain) : prevData;
      prevRgbMode <= rgbMode;
    end
  end
endmodule : vcrb_preview_slice

/* File: rtl/vcrb_ring_ptr.sv */
`timescale 1ns/1ps
module vcrb_ring_ptr #(
  parameter int ADDR_W = 29
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              clear,
  input  wire logic              pixWrite,
  input  wire logic              frameDone,
  input  wire logic [ADDR_W-1:0] frameWords,
  output logic      [ADDR_W-1:0] wrAddr,
  output logic      [ADDR_W-1:0] frameBase,
  output logic                   wrapped
);
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] off_q;
  logic [ADDR_W:0]   pixSum;
  logic [ADDR_W:0]   nextBase;
  logic              wrapEv;

  // a carry out of either sum means the ring rolled past its last word
  assign pixSum    = {1'b0, base_q} + {1'b0, off_q};
  assign nextBase  = {1'b0, base_q} + {1'b0, frameWords};
  assign wrAddr    = pixSum[ADDR_W-1:0];
  assign frameBase = base_q;
  assign wrapEv    = (pixWrite && pixSum[ADDR_W]) || (frameDone && nextBase[ADDR_W]);

  // frame base and in-frame offset
  always_ff @(posedge core_clk) begin
    if (!reset_n || clear) begin
      base_q <= '0;
      off_q  <= '0;
    end else if (frameDone) begin
      base_q <= nextBase[ADDR_W-1:0];
      off_q  <= '0;
    end else if (pixWrite) begin
      off_q  <= off_q + 1'b1;
    end
  end

  // sticky wrap flag; a wrap event in the clear cycle still sets it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrapped <= 1'b0;
    end else begin
      wrapped <= (wrapped && !clear) || wrapEv;
    end
  end
endmodule : vcrb_ring_ptr

/* File: rtl/vcrb_top.sv */
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module vcrb_top
  import vcrb_pkg::*;
#(
  parameter int ADDR_W = 29
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pixValid,
  input  wire logic              pixFrameStart,
  input  wire logic              pixFrameEnd,
  input  wire logic [DIM_W-1:0]  pixRow,
  input  wire logic [DIM_W-1:0]  pixCol,
  input  wire logic [9:0]        pixData,
  input  wire logic              extTrigger,
  input  wire logic              dlReq,
  output logic                   dlGrant,
  output logic                   writingFlag,
  output logic                   memWrEn,
  output logic [ADDR_W-1:0]      memWrAddr,
  output logic [9:0]             memWrData,
  output logic                   calStart,
  output logic                   prevValid,
  output logic [7:0]             prevData,
  output logic                   preview_rgb_mode,
  input  wire logic [DIM_W-1:0]  bootWidth,
  input  wire logic [DIM_W-1:0]  bootHeight,
  input  wire logic [DIM_W-1:0]  bootTop,
  input  wire logic [DIM_W-1:0]  bootLeft,
  input  wire logic [15:0]       bootPost,
  input  wire logic [1:0]        bootGain,
  input  wire logic              bootRgbMode
);
  import vcrb_pkg::*;

  // bus slave state
  logic              awHeld_q;
  logic [7:0]        awAddr_q;
  logic              wHeld_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              doWrite;
  // configuration
  logic [DIM_W-1:0]  width_q;
  logic [DIM_W-1:0]  height_q;
  logic [DIM_W-1:0]  top_q;
  logic [DIM_W-1:0]  left_q;
  logic [15:0]       post_q;
  logic [1:0]        gain_q;
  logic              rgb_q;
  logic              bootPend_q;
  logic [31:0]       merged;
  // control
  vcrb_state_e       state_q;
  logic [15:0]       postCnt_q;
  logic              inFrame_q;
  logic              trigFlag_q;
  logic              extTrig_q;
  logic              cmdClear;
  logic              cmdReset;
  logic              cmdCal;
  logic              cmdTrig;
  logic              trigEv;
  logic              writing;
  logic              frameDone;
  // capture datapath
  logic [12:0]       relRow;
  logic [12:0]       relCol;
  logic              inRoi;
  logic              writeNow;
  logic              prevIn;
  logic [ADDR_W-1:0] ringAddr;
  logic [ADDR_W-1:0] ringBase;
  logic              wrapFlag;
  logic [23:0]       frameWords;

  // offsets that answer OKAY; everything else gets SLVERR
  function automatic logic regKnown(input logic [7:0] a);
    case (a)
      OFS_CMD, OFS_STATUS, OFS_WIDTH, OFS_HEIGHT, OFS_TOP,
      OFS_LEFT, OFS_POST, OFS_PREVIEW, OFS_WRPTR: regKnown = 1'b1;
      default:                                   regKnown = 1'b0;
    endcase
  endfunction : regKnown

  // byte-lane merge of write data over the current register value
  function automatic logic [31:0] laneMerge(input logic [31:0] cur, input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      laneMerge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : cur[i*8 +: 8];
    end
  endfunction : laneMerge

  // register readback, also the base for byte-lane merges
  function automatic logic [31:0] regRead(input logic [7:0] a);
    case (a)
      OFS_STATUS:  regRead = {26'h0, state_q, 1'b0, trigFlag_q, wrapFlag, writing};
      OFS_WIDTH:   regRead = {20'h0, width_q};
      OFS_HEIGHT:  regRead = {20'h0, height_q};
      OFS_TOP:     regRead = {20'h0, top_q};
      OFS_LEFT:    regRead = {20'h0, left_q};
      OFS_POST:    regRead = {16'h0, post_q};
      OFS_PREVIEW: regRead = {27'h0, rgb_q, 2'h0, gain_q};
      OFS_WRPTR:   regRead = 32'(ringBase);
      default:     regRead = 32'h0000_0000;
    endcase
  endfunction : regRead

  // address and data are taken independently, each held until the write fires
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign merged        = laneMerge(regRead(awAddr_q), wData_q, wStrb_q);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= regKnown(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one outstanding read, data the cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= regRead(s_axi_araddr);
      s_axi_rresp  <= regKnown(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // command pulses; only byte lane 0 carries command bits
  assign cmdClear = doWrite && awAddr_q == OFS_CMD && wStrb_q[0] && wData_q[CMD_CLEAR_BIT];
  assign cmdReset = doWrite && awAddr_q == OFS_CMD && wStrb_q[0] && wData_q[CMD_RESET_BIT];
  assign cmdCal   = doWrite && awAddr_q == OFS_CMD && wStrb_q[0] && wData_q[CMD_CAL_BIT];
  assign cmdTrig  = doWrite && awAddr_q == OFS_CMD && wStrb_q[0] && wData_q[CMD_TRIG_BIT];

  // configuration: boot values load one cycle after reset or on a reset command
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bootPend_q <= 1'b1;
      width_q    <= RST_DIM;
      height_q   <= RST_DIM;
      top_q      <= RST_DIM;
      left_q     <= RST_DIM;
      post_q     <= RST_POST;
      gain_q     <= RST_GAIN;
      rgb_q      <= 1'b0;
    end else if (bootPend_q) begin
      bootPend_q <= 1'b0;
      width_q    <= bootWidth;
      height_q   <= bootHeight;
      top_q      <= bootTop;
      left_q     <= bootLeft;
      post_q     <= bootPost;
      gain_q     <= bootGain;
      rgb_q      <= bootRgbMode;
    end else if (cmdReset) begin
      bootPend_q <= 1'b1;
    end else if (doWrite) begin
      case (awAddr_q)
        // widths off the ten-pixel grid are dropped, old value kept
        OFS_WIDTH:   if (merged[11:0] % WIDTH_STEP == 12'h000) begin
          width_q <= merged[11:0];
        end
        OFS_HEIGHT:  height_q <= merged[11:0];
        OFS_TOP:     top_q    <= merged[11:0];
        OFS_LEFT:    left_q   <= merged[11:0];
        OFS_POST:    post_q   <= merged[15:0];
        OFS_PREVIEW: begin
          gain_q <= merged[PV_GAIN_LSB +: 2];
          rgb_q  <= merged[PV_RGB_BIT];
        end
        default: ;
      endcase
    end
  end

  // one-shot calibrate request toward the sensor column converters
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      calStart <= 1'b0;
    end else begin
      calStart <= cmdCal;
    end
  end

  // trigger edge: the external pin is synchronous, a rising edge counts
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      extTrig_q <= 1'b0;
    end else begin
      extTrig_q <= extTrigger;
    end
  end
  assign trigEv = cmdTrig || (extTrigger && !extTrig_q);

  // capture state machine; reset wins over an erase in the same write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q   <= VCRB_IDLE;
      postCnt_q <= 16'h0000;
    end else if (cmdReset) begin
      state_q   <= VCRB_IDLE;
    end else if (cmdClear) begin
      state_q   <= VCRB_CAPTURE;
    end else begin
      case (state_q)
        VCRB_IDLE: state_q <= VCRB_IDLE;
        VCRB_CAPTURE: if (trigEv) begin
          state_q   <= (post_q == 16'h0000) ? VCRB_STOP : VCRB_POST;
          postCnt_q <= post_q;
        end
        VCRB_POST: if (frameDone) begin
          postCnt_q <= postCnt_q - 16'h0001;
          if (postCnt_q == 16'h0001) state_q <= VCRB_STOP;
        end
        VCRB_STOP: state_q <= VCRB_STOP;
        default:   state_q <= VCRB_IDLE;
      endcase
    end
  end

  assign writing     = (state_q == VCRB_CAPTURE) || (state_q == VCRB_POST);
  assign writingFlag = writing;
  assign dlGrant     = dlReq && !writing;

  // trigger seen flag, set wins over the erase that clears it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      trigFlag_q <= 1'b0;
    end else begin
      trigFlag_q <= (trigFlag_q && !cmdClear && !cmdReset)
                    || (trigEv && state_q == VCRB_CAPTURE);
    end
  end

  // capture joins at the next frame start; a trigger with post_q zero, a clear or a reset can stop it mid-frame
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      inFrame_q <= 1'b0;
    end else if (cmdClear || cmdReset || !writing || pixFrameEnd) begin
      inFrame_q <= 1'b0;
    end else if (pixFrameStart) begin
      inFrame_q <= 1'b1;
    end
  end
  assign frameDone = pixFrameEnd && inFrame_q && writing;

  // region test relative to the programmed corner
  assign relRow     = {1'b0, pixRow} - {1'b0, top_q};
  assign relCol     = {1'b0, pixCol} - {1'b0, left_q};
  assign inRoi      = pixRow >= top_q && pixCol >= left_q
                      && relRow < {1'b0, height_q} && relCol < {1'b0, width_q};
  assign writeNow   = pixValid && inRoi && inFrame_q && writing && !cmdClear && !cmdReset;
  assign prevIn     = writeNow && relRow < PREVIEW_ROWS && relCol < PREVIEW_COLS;
  assign frameWords = width_q * height_q;

  vcrb_ring_ptr #(
    .ADDR_W     (ADDR_W)
  ) u_ring (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .clear      (cmdClear || cmdReset),
    .pixWrite   (writeNow),
    .frameDone  (frameDone),
    .frameWords (ADDR_W'(frameWords)),
    .wrAddr     (ringAddr),
    .frameBase  (ringBase),
    .wrapped    (wrapFlag)
  );

  // memory write port; samples go out untouched by gain or colour mode
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      memWrEn   <= 1'b0;
      memWrAddr <= '0;
      memWrData <= 10'h000;
    end else begin
      memWrEn   <= writeNow;
      memWrAddr <= writeNow ? ringAddr : memWrAddr;
      memWrData <= writeNow ? pixData : memWrData;
    end
  end

  vcrb_preview_slice u_prev (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .inValid     (prevIn),
    .inData      (pixData),
    .gain        (gain_q),
    .rgbMode     (rgb_q),
    .prevValid   (prevValid),
    .prevData    (prevData),
    .prevRgbMode (preview_rgb_mode)
  );
endmodule : vcrb_top

/* File: test/test_video_capture_ring_buffer.sv */
`timescale 1ns/1ps
module test_video_capture_ring_buffer;
  import vcrb_pkg::*;
  logic core_clk = 0, reset_n = 0, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, prevData;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, bootGain = 1;
  logic pixValid = 0, pixFrameStart = 0, pixFrameEnd = 0, extTrigger = 0, dlReq = 0;
  logic [11:0] pixRow = 0, pixCol = 0, bootWidth = 10, bootHeight = 2, bootTop = 1, bootLeft = 2;
  logic [9:0] pixData = 0, memWrData, e, em;
  logic [15:0] bootPost = 2;
  logic [5:0] memWrAddr;
  logic dlGrant, writingFlag, memWrEn, calStart, prevValid, preview_rgb_mode, bootRgbMode = 0;
  logic mWr = 0, trig = 0, fw;
  int miscompares, cmp_count, expAddr, gain, rgb, post, calCnt;
  logic [9:0] expQ[$];
  always #12.5 core_clk = ~core_clk;
  vcrb_top #(.ADDR_W(6)) dut (.*);
  vcrb_host_model host (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    host.rd(a, d, r);
    chk(d, exp);
  endtask : rc
  task automatic wc(input logic [7:0] a, input logic [31:0] v);
    host.wr(a, v, r);
    chk(r, RESP_OKAY);
  endtask : wc
  function automatic logic [7:0] sl(input logic [9:0] v);
    sl = 8'(v >> (gain > 1 ? 0 : 2 - gain));
  endfunction : sl
  // one 4x14 sensor frame; the 10x2 region at row 1, col 2 is what gets stored
  task automatic frame();
    @(posedge core_clk) pixFrameStart <= 1;
    fw = mWr;
    for (int y = 0; y < 4; y++) for (int x = 0; x < 14; x++) begin
      @(posedge core_clk) pixFrameStart <= 0;
      pixValid <= 1;
      pixRow <= 12'(y);
      pixCol <= 12'(x);
      e = 10'($urandom % 1024);
      pixData <= e;
      if (fw && y >= 1 && y < 3 && x >= 2 && x < 12) expQ.push_back(e);
    end
    @(posedge core_clk) pixValid <= 0;
    pixFrameEnd <= 1;
    @(posedge core_clk) pixFrameEnd <= 0;
    if (fw && trig && --post <= 0) mWr = 0;
    repeat (3) @(posedge core_clk);
    chk(expQ.size(), 0);
    chk(writingFlag, mWr);
  endtask : frame
  // stored words and preview pixels against the queued model
  always @(posedge core_clk) begin
    if (reset_n && memWrEn) begin
      em = expQ.size() ? expQ.pop_front() : 10'bx;
      chk(memWrAddr, expAddr);
      chk(memWrData, em);
      chk(prevValid, 1);
      chk(prevData, sl(em));
      expAddr = (expAddr + 1) % 64;
    end
    if (prevValid) chk(preview_rgb_mode, rgb);
    if (calStart) calCnt++;
  end
  task automatic final_report();
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // a hung handshake must not stall the run
  initial begin
    #500us;
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(69345));
    repeat (5) @(posedge core_clk);
    reset_n <= 1;
    @(posedge core_clk);
    rc(OFS_STATUS, 0);
    rc(OFS_WIDTH, 10);
    frame();
    wc(OFS_CMD, 4);
    repeat (3) @(posedge core_clk);
    chk(calCnt, 1);
    wc(OFS_CMD, 1);
    mWr = 1;
    rc(OFS_STATUS, 32'h11);
    dlReq <= 1;
    @(posedge core_clk) chk(dlGrant, 0);
    wc(OFS_WIDTH, 15);
    rc(OFS_WIDTH, 10);
    host.wr(8'h40, 1, r);
    chk(r, RESP_SLVERR);
    for (int g = 0; g < 5; g++) begin
      gain = g % 4;
      rgb = g & 1;
      wc(OFS_PREVIEW, gain | (rgb << 4));
      frame();
      rc(OFS_STATUS, g < 3 ? 32'h11 : 32'h13);
    end
    wc(OFS_CMD, 8);
    trig = 1;
    post = 2;
    rc(OFS_STATUS, 32'h27);
    frame();
    frame();
    rc(OFS_STATUS, 32'h36);
    chk(dlGrant, 1);
    frame();
    wc(OFS_CMD, 1);
    {mWr, trig, expAddr} = {1'b1, 1'b0, 32'd0};
    rc(OFS_STATUS, 32'h11);
    frame();
    wc(OFS_POST, 0);
    @(posedge core_clk) extTrigger <= 1;
    @(posedge core_clk) extTrigger <= 0;
    mWr = 0;
    rc(OFS_STATUS, 32'h34);
    wc(OFS_HEIGHT, 3);
    wc(OFS_CMD, 2);
    rc(OFS_STATUS, 0);
    rc(OFS_HEIGHT, 2);
    frame();
    final_report();
  end
endmodule : test_video_capture_ring_buffer
bind vcrb_top vcrb_top_props #(.ADDR_W(ADDR_W)) u_props (.core_clk, .reset_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pixData, .dlReq, .dlGrant, .writingFlag,
  .memWrEn, .memWrAddr, .memWrData, .calStart, .prevValid, .prevData);

/* File: test/vcrb_host_model.sv */
`timescale 1ns/1ps
module vcrb_host_model (
  input wire logic        core_clk,
  output logic [7:0]      s_axi_awaddr,
  output logic            s_axi_awvalid,
  input wire logic        s_axi_awready,
  output logic [31:0]     s_axi_wdata,
  output logic [3:0]      s_axi_wstrb,
  output logic            s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  output logic            s_axi_bready,
  output logic [7:0]      s_axi_araddr,
  output logic            s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  output logic            s_axi_rready
);
  // host side is quiet until the bench asks for a transfer
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // settings go out one word at a time, only once the bench decided them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // read waits for the answer however long it takes
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : vcrb_host_model

/* File: test/vcrb_top_props.sv */
`timescale 1ns/1ps
module vcrb_top_props #(
  parameter int ADDR_W = 29
) (
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic [9:0]        pixData,
  input wire logic              dlReq,
  input wire logic              dlGrant,
  input wire logic              writingFlag,
  input wire logic              memWrEn,
  input wire logic [ADDR_W-1:0] memWrAddr,
  input wire logic [9:0]        memWrData,
  input wire logic              calStart,
  input wire logic              prevValid,
  input wire logic [7:0]        prevData
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_grant_gate: assert property (dlGrant == (dlReq && !writingFlag))
    else $error("readout granted while writing");
  chk_write_cause: assert property (memWrEn |-> $past(writingFlag))
    else $error("memory write while not writing");
  chk_raw_store: assert property (memWrEn |-> memWrData == $past(pixData))
    else $error("stored sample not raw");
  chk_fill_step: assert property (memWrEn && $past(memWrEn)
    |-> memWrAddr == ADDR_W'($past(memWrAddr) + 1'b1))
    else $error("write address not sequential");
  chk_prev_slice: assert property (prevValid |-> memWrEn &&
    (prevData == memWrData[9:2] || prevData == memWrData[8:1] || prevData == memWrData[7:0]))
    else $error("preview not a bit window of the sample");
  chk_cal_pulse: assert property (calStart |-> !$past(calStart) ##1 !calStart)
    else $error("calibrate start not a single pulse");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with response pending");
endmodule : vcrb_top_props
